// file: include/amcc_pkg.sv
// constants, register map and link format derivation for the mode/config block
// assumes a single 200 MHz clock that also paces the converter sample clock count
package amcc_pkg;

   // ****************************************
   // register map (15-bit spi addresses)
   // ****************************************
   localparam logic [14:0] ADDR_TRIM_ONE   = 15'h0037;
   localparam logic [14:0] ADDR_SOFT_KICK  = 15'h006c;
   localparam logic [14:0] ADDR_TRIM_TWO   = 15'h029a;
   localparam logic [14:0] ADDR_TRIM_THREE = 15'h029b;
   localparam logic [14:0] ADDR_TRIM_FOUR  = 15'h029c;
   localparam logic [14:0] ADDR_CAL_CTRL   = 15'h0061;
   localparam logic [14:0] ADDR_LINK_CTRL  = 15'h0200;
   localparam logic [14:0] ADDR_FORMAT_SEL = 15'h0201;
   localparam logic [14:0] ADDR_FRAMES_M1  = 15'h0202;
   localparam logic [14:0] ADDR_LANE_FAULT = 15'h02c2;

   // cal_ctrl fields
   localparam int CAL_EN_BIT    = 0;
   localparam int CAL_MODE_LSB  = 1;
   localparam int TIMED_SEL_BIT = 4;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] TRIM_ONE_RST   = 8'h4b;
   localparam logic [7:0] TRIM_TWO_RST   = 8'h0f;
   localparam logic [7:0] TRIM_THREE_RST = 8'h04;
   localparam logic [7:0] TRIM_FOUR_RST  = 8'h00;
   localparam logic [2:0] FORMAT_RST     = 3'h0;
   localparam logic [7:0] FRAMES_M1_RST  = 8'h1f;

   // ****************************************
   // spi frame: rw bit, 15 address bits, 8 data bits
   // ****************************************
   localparam logic [4:0] SPI_ADDR_DONE = 5'h0f;
   localparam logic [4:0] SPI_LAST_BIT  = 5'h17;

   // ****************************************
   // timed core swap window, in sample clocks
   // ****************************************
   localparam int SWAP_MIN_CYC   = 500;
   localparam int SWAP_MAX_CYC   = 1000;
   localparam int SWAP_DELAY_CYC = (SWAP_MIN_CYC + SWAP_MAX_CYC) / 2;

   typedef enum logic [1:0] {
      AMCC_CAL_FOREGROUND = 2'b00,
      AMCC_CAL_BACKGROUND = 2'b01,
      AMCC_CAL_LOWPOWER   = 2'b10,
      AMCC_CAL_RSVD       = 2'b11
   } amcc_cal_mode_t;

   typedef struct packed {
      logic       enc_64b66b;
      logic       send_align;
      logic [3:0] lanes;
      logic [3:0] octets;
      logic [6:0] rate_x4;
      logic [8:0] frames_per_mf;
      logic [1:0] ext_mb;
   } amcc_xport_t;

   // the selector code fixes every transport parameter but frames_per_mf, which codes 0-3 take from km1 + 1; rate is kept in quarter units
   function automatic amcc_xport_t amcc_derive(input logic [2:0] sel, input logic [7:0] km1);
      amcc_xport_t x;
      x = '0;
      unique case (sel)
         3'h0: begin x.lanes = 4'h8; x.octets = 4'h8; x.rate_x4 = 7'h20; end
         3'h1: begin x.lanes = 4'h6; x.octets = 4'h2; x.rate_x4 = 7'h28; end
         3'h2: begin x.lanes = 4'h4; x.octets = 4'h1; x.rate_x4 = 7'h28; end
         3'h3: begin x.lanes = 4'h4; x.octets = 4'h5; x.rate_x4 = 7'h32; end
         3'h4: begin x.lanes = 4'h3; x.octets = 4'h2; x.rate_x4 = 7'h42; end
         3'h5: begin x.lanes = 4'h2; x.octets = 4'h2; x.rate_x4 = 7'h42; end
         3'h6: begin x.lanes = 4'h6; x.octets = 4'h2; x.rate_x4 = 7'h21; end
         3'h7: begin x.lanes = 4'h4; x.octets = 4'h1; x.rate_x4 = 7'h21; end
      endcase
      x.enc_64b66b = sel[2];
      x.send_align = !sel[2];
      x.frames_per_mf = sel[2] ? 9'h000 : ({1'b0, km1} + 9'h001);
      x.ext_mb = sel[2] ? 2'h1 : 2'h0;
      return x;
   endfunction

endpackage

// file: design/amcc_swap_timer.sv
// timed converter core swap scheduler
// assumes trigger inputs are synchronous one-clock-wide or level signals on clk
`timescale 1ns/1ps
module amcc_swap_timer #(
   parameter int DELAY_CYC = amcc_pkg::SWAP_DELAY_CYC
) (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  ce,
   // configuration
   input  wire logic                  cal_en,
   input  wire amcc_pkg::amcc_cal_mode_t cal_mode,
   input  wire logic                  timed_swap_select,
   // triggers
   input  wire logic                  calibration_trigger_ball,
   input  wire logic                  soft_kick,
   input  wire logic                  free_swap_due,
   // swap request to the cores
   output logic                       core_swap_go
);

   typedef enum logic [0:0] {
      AMCC_SW_IDLE = 1'b0,
      AMCC_SW_WAIT = 1'b1
   } amcc_sw_state_t;

   typedef struct packed {
      amcc_sw_state_t st;
      logic [10:0]    cnt;
      logic           ball_prev;
      logic           go;
   } amcc_sw_t;

   localparam logic [10:0] LAST = 11'(DELAY_CYC - 1);

   amcc_sw_t q;
   amcc_sw_t d;
   logic     timed;
   logic     trig;

   always_comb begin
      d = q;
      d.go = 1'b0;
      d.ball_prev = calibration_trigger_ball;
      timed = cal_en && cal_mode == amcc_pkg::AMCC_CAL_LOWPOWER && timed_swap_select;
      trig = soft_kick || (calibration_trigger_ball && !q.ball_prev);
      unique case (q.st)
         AMCC_SW_IDLE: begin
            d.cnt = '0;
            if (timed && trig) begin
               d.st = AMCC_SW_WAIT;
            end
         end
         AMCC_SW_WAIT: begin
            d.cnt = q.cnt + 11'h001;
            if (!timed) begin
               d.st = AMCC_SW_IDLE;
            end else if (q.cnt == LAST) begin
               d.st = AMCC_SW_IDLE;
               d.go = 1'b1;
            end
         end
      endcase
      // background calibration swaps when the engine asks, unless timing is user controlled
      if (cal_en && !timed && free_swap_due &&
          (cal_mode == amcc_pkg::AMCC_CAL_BACKGROUND ||
           cal_mode == amcc_pkg::AMCC_CAL_LOWPOWER)) begin
         d.go = 1'b1;
      end
      // foreground mode never swaps cores, so no glitch reaches the data
      if (cal_mode == amcc_pkg::AMCC_CAL_FOREGROUND) begin
         d.go = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '{st: AMCC_SW_IDLE, cnt: 11'h000, ball_prev: 1'b0, go: 1'b0};
      end else if (ce) begin
         q <= d;
      end
   end

   assign core_swap_go = q.go;

endmodule

// file: design/amcc_top.sv
// mode and configuration register bank reached over a 3-wire-plus-select spi port
// assumes spi pins and fault pulses are synchronous to clk; sclk is far slower than clk
`timescale 1ns/1ps
module amcc_top #(
   parameter int LANES     = 8,
   parameter int DELAY_CYC = amcc_pkg::SWAP_DELAY_CYC
) (
   // clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic                     ce,
   // spi port
   input  wire logic                     spi_cs_n,
   input  wire logic                     spi_sclk,
   input  wire logic                     spi_sdi,
   output logic                          spi_sdo,
   // calibration
   input  wire logic                     calibration_trigger_ball,
   input  wire logic                     free_swap_due,
   output logic                          core_swap_go,
   output logic                          cal_en,
   output amcc_pkg::amcc_cal_mode_t      cal_mode,
   // power trims to the analog cores
   output logic [7:0]                    power_trim_one,
   output logic [7:0]                    power_trim_two,
   output logic [7:0]                    power_trim_three,
   output logic [7:0]                    power_trim_four,
   // serial link control
   input  wire logic [LANES-1:0]         lane_ptr_upset,
   output logic [LANES-1:0]              lane_fifo_fault_flag,
   output logic                          link_reset,
   output logic                          serializer_power_down,
   output logic                          link_clock_enable,
   output amcc_pkg::amcc_xport_t         xport
);

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic                     sclk_prev;
      logic [4:0]               bit_cnt;
      logic [23:0]              shreg;
      logic [7:0]               rd_sh;
      logic                     sdo;
      logic [7:0]               trim1;
      logic [7:0]               trim2;
      logic [7:0]               trim3;
      logic [7:0]               trim4;
      logic                     cal_en;
      amcc_pkg::amcc_cal_mode_t cal_mode;
      logic                     timed_sel;
      logic                     link_en;
      logic [2:0]               fmt;
      logic [7:0]               km1;
      logic [LANES-1:0]         fault;
      logic                     kick;
      logic                     link_rst;
      logic                     ser_pd;
      logic                     clk_on;
      amcc_pkg::amcc_xport_t    xport;
   } amcc_top_state_t;

   amcc_top_state_t q;
   amcc_top_state_t d;

   // ****************************************
   // register read mux
   // ****************************************
   function automatic logic [7:0] rd_mux(input amcc_top_state_t s, input logic [14:0] a);
      logic [7:0] r;
      r = 8'h00;
      unique case (a)
         amcc_pkg::ADDR_TRIM_ONE:   r = s.trim1;
         amcc_pkg::ADDR_TRIM_TWO:   r = s.trim2;
         amcc_pkg::ADDR_TRIM_THREE: r = s.trim3;
         amcc_pkg::ADDR_TRIM_FOUR:  r = s.trim4;
         amcc_pkg::ADDR_CAL_CTRL:   r = {3'h0, s.timed_sel, 1'b0, s.cal_mode, s.cal_en};
         amcc_pkg::ADDR_LINK_CTRL:  r = {7'h00, s.link_en};
         amcc_pkg::ADDR_FORMAT_SEL: r = {5'h00, s.fmt};
         amcc_pkg::ADDR_FRAMES_M1:  r = s.km1;
         amcc_pkg::ADDR_LANE_FAULT: r = 8'(s.fault);
         default:                   r = 8'h00;
      endcase
      return r;
   endfunction

   // ****************************************
   // next state
   // ****************************************
   logic [23:0]      nsh;
   logic [14:0]      wa;
   logic [7:0]       wd;
   logic             wr;
   logic [LANES-1:0] clr;

   always_comb begin
      d = q;
      d.kick = 1'b0;
      d.sclk_prev = spi_sclk;
      nsh = {q.shreg[22:0], spi_sdi};
      wa = nsh[22:8];
      wd = nsh[7:0];
      wr = 1'b0;
      clr = '0;
      if (spi_cs_n) begin
         d.bit_cnt = 5'h00;
         d.sdo = 1'b0;
      end else if (spi_sclk && !q.sclk_prev) begin
         d.shreg = nsh;
         d.bit_cnt = (q.bit_cnt == amcc_pkg::SPI_LAST_BIT) ? 5'h00 : q.bit_cnt + 5'h01;
         if (q.bit_cnt == amcc_pkg::SPI_ADDR_DONE) begin
            d.rd_sh = rd_mux(q, nsh[14:0]);
         end
         // leading bit clear means write
         wr = (q.bit_cnt == amcc_pkg::SPI_LAST_BIT) && !nsh[23];
      end else if (!spi_sclk && q.sclk_prev && q.bit_cnt > amcc_pkg::SPI_ADDR_DONE) begin
         d.sdo = q.rd_sh[7];
         d.rd_sh = {q.rd_sh[6:0], 1'b0};
      end

      if (wr) begin
         unique case (wa)
            amcc_pkg::ADDR_TRIM_ONE:   d.trim1 = wd;
            amcc_pkg::ADDR_TRIM_TWO:   d.trim2 = wd;
            amcc_pkg::ADDR_TRIM_THREE: d.trim3 = wd;
            amcc_pkg::ADDR_TRIM_FOUR:  d.trim4 = wd;
            amcc_pkg::ADDR_SOFT_KICK:  d.kick = 1'b1;
            amcc_pkg::ADDR_CAL_CTRL: begin
               d.cal_en = wd[amcc_pkg::CAL_EN_BIT];
               d.cal_mode = amcc_pkg::amcc_cal_mode_t'(wd[amcc_pkg::CAL_MODE_LSB +: 2]);
               d.timed_sel = wd[amcc_pkg::TIMED_SEL_BIT];
            end
            amcc_pkg::ADDR_LINK_CTRL:  d.link_en = wd[0];
            amcc_pkg::ADDR_FORMAT_SEL: d.fmt = wd[2:0];
            amcc_pkg::ADDR_FRAMES_M1:  d.km1 = wd;
            amcc_pkg::ADDR_LANE_FAULT: clr = wd[LANES-1:0];
            default: ;
         endcase
      end

      // a new upset in the clearing cycle survives the clear
      d.fault = (q.fault & ~clr) | (lane_ptr_upset & {LANES{q.link_en}});

      // fifo logic only runs while enabled, so a 0-then-1 toggle restarts it
      d.link_rst = !d.link_en;
      d.ser_pd = !d.link_en;
      d.clk_on = d.link_en;

      // transport parameters only follow the selector while the link is down
      if (!d.link_en) begin
         d.xport = amcc_pkg::amcc_derive(d.fmt, d.km1);
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.trim1 <= amcc_pkg::TRIM_ONE_RST;
         q.trim2 <= amcc_pkg::TRIM_TWO_RST;
         q.trim3 <= amcc_pkg::TRIM_THREE_RST;
         q.trim4 <= amcc_pkg::TRIM_FOUR_RST;
         q.cal_mode <= amcc_pkg::AMCC_CAL_FOREGROUND;
         q.fmt <= amcc_pkg::FORMAT_RST;
         q.km1 <= amcc_pkg::FRAMES_M1_RST;
         q.link_rst <= 1'b1;
         q.ser_pd <= 1'b1;
         q.xport <= amcc_pkg::amcc_derive(amcc_pkg::FORMAT_RST, amcc_pkg::FRAMES_M1_RST);
      end else if (ce) begin
         q <= d;
      end
   end

   // ****************************************
   // timed swap scheduling
   // ****************************************
   amcc_swap_timer #(
      .DELAY_CYC(DELAY_CYC)
   ) u_swap (
      .clk                      (clk),
      .rst_n                    (rst_n),
      .ce                       (ce),
      .cal_en                   (q.cal_en),
      .cal_mode                 (q.cal_mode),
      .timed_swap_select        (q.timed_sel),
      .calibration_trigger_ball (calibration_trigger_ball),
      .soft_kick                (q.kick),
      .free_swap_due            (free_swap_due),
      .core_swap_go             (core_swap_go)
   );

   assign spi_sdo               = q.sdo;
   assign cal_en                = q.cal_en;
   assign cal_mode              = q.cal_mode;
   assign power_trim_one        = q.trim1;
   assign power_trim_two        = q.trim2;
   assign power_trim_three      = q.trim3;
   assign power_trim_four       = q.trim4;
   assign lane_fifo_fault_flag  = q.fault;
   assign link_reset            = q.link_rst;
   assign serializer_power_down = q.ser_pd;
   assign link_clock_enable     = q.clk_on;
   assign xport                 = q.xport;

endmodule

// file: verification/amcc_props.sv
// concurrent checks on the ports of the mode/config block top
// assumes it is bound onto amcc_top and that everything runs on clk
`timescale 1ns/1ps
module amcc_props #(
   parameter int LANES = 8
) (
   // clock and reset
   input wire logic                     clk,
   input wire logic                     rst_n,
   input wire logic                     ce,
   // spi and calibration
   input wire logic                     spi_cs_n,
   input wire logic                     core_swap_go,
   input wire logic                     cal_en,
   input wire amcc_pkg::amcc_cal_mode_t cal_mode,
   // trims
   input wire logic [7:0]               power_trim_one,
   input wire logic [7:0]               power_trim_two,
   input wire logic [7:0]               power_trim_three,
   // link
   input wire logic [LANES-1:0]         lane_ptr_upset,
   input wire logic [LANES-1:0]         lane_fifo_fault_flag,
   input wire logic                     link_reset,
   input wire logic                     serializer_power_down,
   input wire logic                     link_clock_enable,
   input wire amcc_pkg::amcc_xport_t    xport
);
   // ****************************************
   // properties
   // ****************************************
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_pulse;
      core_swap_go ##1 !core_swap_go;
   endsequence

   AST_SWAP_PULSE: assert property (core_swap_go |-> s_pulse)
      else $error("swap pulse longer than one cycle");
   // the pulse is decided from the configuration of the cycle before it
   AST_SWAP_MODE: assert property (core_swap_go
      |-> $past(cal_en) && $past(cal_mode) != 2'b00)
      else $error("swap outside background calibration");
   AST_FG_NO_SWAP: assert property (cal_mode == 2'b00 && $past(cal_mode) == 2'b00
      |-> !core_swap_go)
      else $error("swap in foreground mode");
   // link_reset low on both cycles means the enable was set at the upset edge
   AST_FAULT_SET: assert property (ce && !link_reset |=> link_reset ||
      ((lane_fifo_fault_flag & $past(lane_ptr_upset)) == $past(lane_ptr_upset)))
      else $error("lane fault flag not set");
   AST_FAULT_HOLD: assert property (spi_cs_n
      |=> !(|($past(lane_fifo_fault_flag) & ~lane_fifo_fault_flag)))
      else $error("fault flag dropped without a write");
   AST_LINK_OFF: assert property (serializer_power_down == link_reset
      && link_clock_enable == !link_reset)
      else $error("link gating inconsistent");
   AST_XPORT_FROZEN: assert property (!link_reset && $past(!link_reset) |-> $stable(xport))
      else $error("transport changed while link enabled");
   AST_XPORT_ENC: assert property (xport.send_align == !xport.enc_64b66b)
      else $error("alignment send wrong for encoding");
   AST_XPORT_E: assert property (xport.ext_mb == {1'b0, xport.enc_64b66b})
      else $error("extended multiblock count wrong");
   AST_XPORT_K: assert property (xport.enc_64b66b |-> xport.frames_per_mf == 9'h000)
      else $error("frames per multiframe used in 64b66b");
   AST_TRIM_RESET: assert property ($rose(rst_n) |-> power_trim_one == 8'h4b
      && power_trim_two == 8'h0f && power_trim_three == 8'h04)
      else $error("trim reset values wrong");
endmodule

bind amcc_top amcc_props #(.LANES(LANES)) chk_u (.clk, .rst_n, .ce, .spi_cs_n, .core_swap_go,
   .cal_en, .cal_mode, .power_trim_one, .power_trim_two, .power_trim_three, .lane_ptr_upset,
   .lane_fifo_fault_flag, .link_reset, .serializer_power_down, .link_clock_enable, .xport);

// file: verification/testbench.sv
// self-checking bench for the mode/config block
// assumes amcc_top and amcc_pkg are compiled first; swap delay shortened for speed
`timescale 1ns/1ps
module testbench;
   // ****************************************
   // signals and model state
   // ****************************************
   localparam int DLY = 8;
   logic                     clk, rst_n, ce, spi_cs_n, spi_sclk, spi_sdi, spi_sdo;
   logic                     calibration_trigger_ball, free_swap_due, core_swap_go, cal_en;
   amcc_pkg::amcc_cal_mode_t cal_mode;
   logic [7:0]               power_trim_one, power_trim_two, power_trim_three, power_trim_four;
   logic [7:0]               lane_ptr_upset, lane_fifo_fault_flag, rd, flg, km1, v;
   logic                     link_reset, serializer_power_down, link_clock_enable;
   amcc_pkg::amcc_xport_t    xport;
   int                       failures, checks_done, n;
   integer                   seed = 32'h3f59020a;
   logic [14:0]              ta[3] = '{15'h037, 15'h29a, 15'h29b};
   logic [7:0]               hp[3] = '{8'h4b, 8'h0f, 8'h04};
   logic [7:0]               lp[3] = '{8'h46, 8'h06, 8'h00};
   int                       ln_t[8] = '{8, 6, 4, 4, 3, 2, 6, 4};
   int                       oc_t[8] = '{8, 2, 1, 5, 2, 2, 2, 1};
   int                       rt_t[8] = '{32, 40, 40, 50, 66, 66, 33, 33};

   amcc_top #(.LANES(8), .DELAY_CYC(DLY)) dut_u (.clk, .rst_n, .ce, .spi_cs_n, .spi_sclk,
      .spi_sdi, .spi_sdo, .calibration_trigger_ball, .free_swap_due, .core_swap_go, .cal_en,
      .cal_mode, .power_trim_one, .power_trim_two, .power_trim_three, .power_trim_four,
      .lane_ptr_upset, .lane_fifo_fault_flag, .link_reset, .serializer_power_down,
      .link_clock_enable, .xport);

   // ****************************************
   // tasks
   // ****************************************
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // sclk phases of 3 clk keep the design's edge detector comfortable
   task automatic spi(input logic r, input logic [14:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      logic [23:0] f;
      f = {r, a, d};
      q = '0;
      spi_cs_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         spi_sclk = 1'b0;
         spi_sdi = f[i];
         tick(3);
         if (i < 8) q[i] = spi_sdo;
         spi_sclk = 1'b1;
         tick(3);
      end
      spi_sclk = 1'b0;
      tick(3);
      spi_cs_n = 1'b1;
      tick(3);
   endtask

   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      logic [7:0] q;
      spi(1'b0, a, d, q);
   endtask

   task automatic results();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic wait_go(output int k);
      k = 0;
      while (core_swap_go !== 1'b1 && k < 2000) begin
         tick(1);
         k++;
      end
      if (k >= 2000) begin
         failures++;
         results();
      end
   endtask

   // ****************************************
   // stimulus
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      spi_cs_n = 1'b1;
      spi_sclk = 1'b0;
      spi_sdi = 1'b0;
      calibration_trigger_ball = 1'b0;
      free_swap_due = 1'b0;
      lane_ptr_upset = '0;
      failures = 0;
      checks_done = 0;
      repeat (6) @(posedge clk);
      #1 rst_n = 1'b1;
      chk("link_rst", 32'h6, {link_reset, serializer_power_down, link_clock_enable});
      for (int i = 0; i < 3; i++) begin
         spi(1'b1, ta[i], 8'h00, rd);
         chk("trim_rst", hp[i], rd);
         wr(ta[i], lp[i]);
         spi(1'b1, ta[i], 8'h00, rd);
         chk("trim_low", lp[i], rd);
      end
      chk("trim_ports", {lp[0], lp[1], lp[2]}, {power_trim_one, power_trim_two, power_trim_three});
      for (int i = 0; i < 3; i++) wr(ta[i], hp[i]);
      chk("trim_hp", {hp[0], hp[1], hp[2]}, {power_trim_one, power_trim_two, power_trim_three});
      v = $random(seed);
      wr(15'h29c, v);
      chk("trim4", v, power_trim_four);
      wr(15'h123, v);
      spi(1'b1, 15'h123, 8'h00, rd);
      chk("unmapped", 0, rd);
      $display("test trims done");
      for (int s = 0; s < 8; s++) begin
         km1 = $random(seed);
         wr(15'h201, s[7:0]);
         wr(15'h202, km1);
         chk("lanes", ln_t[s], xport.lanes);
         chk("octets", oc_t[s], xport.octets);
         chk("rate", rt_t[s], xport.rate_x4);
         chk("enc", {s >= 4, s < 4}, {xport.enc_64b66b, xport.send_align});
         chk("k", s >= 4 ? 0 : km1 + 1, xport.frames_per_mf);
         chk("e", s >= 4 ? 1 : 0, xport.ext_mb);
      end
      wr(15'h200, 8'h01);
      chk("link_on", 32'h1, {link_reset, serializer_power_down, link_clock_enable});
      wr(15'h201, 8'h00);
      chk("frozen", 4, xport.lanes);
      $display("test format done");
      flg = 8'h00;
      repeat (4) begin
         v = $random(seed);
         lane_ptr_upset = v;
         tick(1);
         lane_ptr_upset = '0;
         flg |= v;
         tick(1);
         chk("flags", flg, lane_fifo_fault_flag);
         v = $random(seed);
         wr(15'h2c2, v);
         flg &= ~v;
         chk("flags_clr", flg, lane_fifo_fault_flag);
      end
      // an upset held across the clearing write must win over the clear
      lane_ptr_upset = 8'h01;
      wr(15'h2c2, 8'h01);
      flg |= 8'h01;
      chk("set_wins", flg, lane_fifo_fault_flag);
      // with the clock enable low no upset may be taken
      ce = 1'b0;
      lane_ptr_upset = ~flg;
      tick(2);
      lane_ptr_upset = '0;
      ce = 1'b1;
      tick(1);
      chk("ce_frozen", flg, lane_fifo_fault_flag);
      wr(15'h200, 8'h00);
      chk("link_off", 32'h6, {link_reset, serializer_power_down, link_clock_enable});
      lane_ptr_upset = 8'hff;
      tick(2);
      lane_ptr_upset = '0;
      wr(15'h200, 8'h01);
      chk("link_back", 32'h1, {link_reset, serializer_power_down, link_clock_enable});
      chk("flags_kept", flg, lane_fifo_fault_flag);
      $display("test faults done");
      wr(15'h061, 8'h15);
      chk("cal", 32'h6, {cal_en, cal_mode});
      calibration_trigger_ball = 1'b1;
      wait_go(n);
      calibration_trigger_ball = 1'b0;
      chk("ball_delay", DLY + 1, n);
      tick(2);
      wr(15'h06c, 8'h01);
      wait_go(n);
      // the write task idles 8 clocks after the landing edge, the kick lands one later
      chk("kick_delay", DLY - 7, n);
      free_swap_due = 1'b1;
      tick(1);
      chk("timed_free", 0, core_swap_go);
      free_swap_due = 1'b0;
      wr(15'h061, 8'h03);
      free_swap_due = 1'b1;
      tick(1);
      chk("free_swap", 1, core_swap_go);
      free_swap_due = 1'b0;
      tick(1);
      chk("free_once", 0, core_swap_go);
      wr(15'h061, 8'h01);
      n = 0;
      for (int i = 0; i < 30; i++) begin
         calibration_trigger_ball = i[0];
         free_swap_due = i[1];
         tick(1);
         if (core_swap_go !== 1'b0) n++;
      end
      chk("fg_swaps", 0, n);
      $display("test swaps done");
      results();
   end
endmodule
